// >>> hdl/dbgw_write_check.sv
`timescale 1ns/1ps
module dbgw_write_check #(
   parameter logic [63:0] THREAD_FLAGS_OFFSET = 64'h0000_0000_0000_0008
) (
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      sys_rst,
   // Instruction issue
   input  wire logic                      issue_valid,
   input  wire logic [31:0]               leaf_code,
   input  wire logic [1:0]                current_privilege_level,
   input  wire logic                      long_mode_active_bit,
   input  wire logic                      code_long_bit,
   input  wire logic [63:0]               target_pointer_register,
   input  wire logic [63:0]               write_data_register,
   input  wire logic                      seg_violation,
   input  wire logic                      seg_unusable,
   output logic                           issue_ready,
   // Completion
   output logic                           done_pulse,
   output dbgw_pkg::dbgw_result_s         result,
   // Page map lookup
   output logic                           map_req,
   output logic [63:0]                    map_addr,
   input  wire logic                      map_ack,
   input  wire logic                      in_page_cache,
   input  wire logic                      map_busy,
   input  wire dbgw_pkg::dbgw_map_entry_s map_entry,
   input  wire logic [7:0]                page_permission_bits,
   // Enclave control structure attribute lookup
   output logic                           attr_req,
   output logic [15:0]                    owning_enclave_pointer,
   input  wire logic                      attr_ack,
   input  wire logic                      attr_debug,
   // Memory write
   output logic                           mem_wr,
   output logic [63:0]                    mem_addr,
   output logic [63:0]                    mem_data,
   output logic [7:0]                     mem_byte_en,
   input  wire logic                      mem_ack
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   dbgw_pkg::dbgw_state_e  state_reg, state_next;
   dbgw_pkg::dbgw_result_s result_reg, result_next;
   logic        wide_mode_flag_reg, wide_mode_flag_next;
   logic [63:0] addr_reg, addr_next;
   logic [63:0] data_reg, data_next;
   logic [15:0] eid_reg, eid_next;
   logic        done_reg, done_next;

   logic        wide_now;
   logic        misaligned;
   logic        non_canonical;
   logic [16:0] canon_top;
   logic        thread_bad;

   assign wide_now = long_mode_active_bit & code_long_bit;

   assign misaligned = wide_now ? ((target_pointer_register & dbgw_pkg::ALIGN8_MASK) != 64'h0)
                                : ((target_pointer_register & dbgw_pkg::ALIGN4_MASK) != 64'h0);

   assign canon_top     = target_pointer_register[63:dbgw_pkg::CANON_MSB];
   assign non_canonical = wide_now & (canon_top != 17'h0) & (canon_top != 17'h1FFFF);

   assign thread_bad = (addr_reg & dbgw_pkg::THREAD_WORD_MASK) !=
                       (THREAD_FLAGS_OFFSET & dbgw_pkg::THREAD_WORD_MASK);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_next          = state_reg;
      result_next         = result_reg;
      wide_mode_flag_next = wide_mode_flag_reg;
      addr_next           = addr_reg;
      data_next           = data_reg;
      eid_next            = eid_reg;
      done_next           = 1'b0;
      case (state_reg)
         dbgw_pkg::DBGW_IDLE: begin
            if (issue_valid && leaf_code == dbgw_pkg::LEAF_DEBUG_WRITE) begin
               wide_mode_flag_next    = wide_now;
               addr_next              = target_pointer_register;
               // upper half cleared in narrow mode
               data_next              = wide_now ? write_data_register : {32'h0, write_data_register[31:0]};
               result_next.fault      = dbgw_pkg::DBGW_FLT_NONE;
               result_next.fault_addr = 64'h0;
               result_next.error_code = 16'h0;
               state_next             = dbgw_pkg::DBGW_MAP;
               if (current_privilege_level != 2'h0) begin
                  result_next.fault = dbgw_pkg::DBGW_FLT_PROT;
                  state_next        = dbgw_pkg::DBGW_DONE;
               end else if (misaligned || non_canonical || seg_violation || seg_unusable) begin
                  result_next.fault = dbgw_pkg::DBGW_FLT_PROT;
                  state_next        = dbgw_pkg::DBGW_DONE;
               end
            end
         end
         dbgw_pkg::DBGW_MAP: begin
            if (map_ack) begin
               if (!in_page_cache) begin
                  result_next.fault      = dbgw_pkg::DBGW_FLT_PAGE;
                  result_next.fault_addr = addr_reg;
                  state_next             = dbgw_pkg::DBGW_DONE;
               end else if (map_busy) begin
                  result_next.fault = dbgw_pkg::DBGW_FLT_PROT;
                  state_next        = dbgw_pkg::DBGW_DONE;
               end else if (!map_entry.valid ||
                            !(map_entry.is_regular || map_entry.is_thread)) begin
                  result_next.fault      = dbgw_pkg::DBGW_FLT_PAGE;
                  result_next.fault_addr = addr_reg;
                  state_next             = dbgw_pkg::DBGW_DONE;
               end else if (map_entry.is_thread && thread_bad) begin
                  result_next.fault = dbgw_pkg::DBGW_FLT_PROT;
                  state_next        = dbgw_pkg::DBGW_DONE;
               end else begin
                  eid_next   = map_entry.enclave_id;
                  state_next = dbgw_pkg::DBGW_ATTR;
               end
            end
         end
         dbgw_pkg::DBGW_ATTR: begin
            if (attr_ack) begin
               if (!attr_debug) begin
                  result_next.fault = dbgw_pkg::DBGW_FLT_PROT;
                  state_next        = dbgw_pkg::DBGW_DONE;
               end else begin
                  state_next = dbgw_pkg::DBGW_WRITE;
               end
            end
         end
         dbgw_pkg::DBGW_WRITE: begin
            if (mem_ack) begin
               state_next = dbgw_pkg::DBGW_DONE;
            end
         end
         dbgw_pkg::DBGW_DONE: begin
            done_next  = 1'b1;
            state_next = dbgw_pkg::DBGW_IDLE;
         end
         default: begin
            state_next = dbgw_pkg::DBGW_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg          <= dbgw_pkg::DBGW_IDLE;
         result_reg         <= '0;
         wide_mode_flag_reg <= 1'b0;
         addr_reg           <= 64'h0;
         data_reg           <= 64'h0;
         eid_reg            <= 16'h0;
         done_reg           <= 1'b0;
      end else begin
         state_reg          <= state_next;
         result_reg         <= result_next;
         wide_mode_flag_reg <= wide_mode_flag_next;
         addr_reg           <= addr_next;
         data_reg           <= data_next;
         eid_reg            <= eid_next;
         done_reg           <= done_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // permission bits never read; they stay unconnected on purpose
   assign issue_ready            = (state_reg == dbgw_pkg::DBGW_IDLE);
   assign done_pulse             = done_reg;
   assign result                 = result_reg;
   assign map_req                = (state_reg == dbgw_pkg::DBGW_MAP);
   assign map_addr               = addr_reg;
   assign attr_req               = (state_reg == dbgw_pkg::DBGW_ATTR);
   assign owning_enclave_pointer = eid_reg;
   assign mem_wr                 = (state_reg == dbgw_pkg::DBGW_WRITE);
   assign mem_addr               = addr_reg;
   assign mem_data    = data_reg;
   assign mem_byte_en = wide_mode_flag_reg ? dbgw_pkg::BYTES_WIDE : dbgw_pkg::BYTES_NARROW;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_priv_issue;
      issue_ready && issue_valid && leaf_code == dbgw_pkg::LEAF_DEBUG_WRITE
      && current_privilege_level != 2'h0;
   endsequence

   // Completion steps shared by the fault properties
   sequence s_end_prot;
      done_pulse && result.fault == dbgw_pkg::DBGW_FLT_PROT && result.error_code == 16'h0;
   endsequence

   sequence s_end_page;
      done_pulse && result.fault == dbgw_pkg::DBGW_FLT_PAGE && result.fault_addr == map_addr;
   endsequence

   // Lookup answered with a resident, idle, valid entry
   sequence s_map_clean;
      map_req && map_ack && in_page_cache && !map_busy && map_entry.valid;
   endsequence

   property p_priv_prot;
      @(posedge core_clk) disable iff (sys_rst)
      s_priv_issue |=> !map_req ##1 s_end_prot;
   endproperty
   a_priv_prot: assert property (p_priv_prot) else $error("privilege fault missing");

   property p_align_prot;
      @(posedge core_clk) disable iff (sys_rst)
      (issue_ready && issue_valid && leaf_code == dbgw_pkg::LEAF_DEBUG_WRITE && misaligned)
      |-> ##2 s_end_prot;
   endproperty
   a_align_prot: assert property (p_align_prot) else $error("alignment fault missing");

   property p_other_leaf;
      @(posedge core_clk) disable iff (sys_rst)
      (issue_ready && issue_valid && leaf_code != dbgw_pkg::LEAF_DEBUG_WRITE)
      |=> issue_ready && !map_req;
   endproperty
   a_other_leaf: assert property (p_other_leaf) else $error("other leaf taken");

   property p_wide_latch;
      @(posedge core_clk) disable iff (sys_rst)
      (issue_ready && issue_valid && leaf_code == dbgw_pkg::LEAF_DEBUG_WRITE)
      |=> wide_mode_flag_reg == $past(long_mode_active_bit && code_long_bit);
   endproperty
   a_wide_latch: assert property (p_wide_latch) else $error("mode flag wrong");

   property p_cache_page;
      @(posedge core_clk) disable iff (sys_rst)
      (map_req && map_ack && !in_page_cache)
      |=> ##1 s_end_page;
   endproperty
   a_cache_page: assert property (p_cache_page) else $error("cache page fault missing");

   property p_busy_prot;
      @(posedge core_clk) disable iff (sys_rst)
      (map_req && map_ack && in_page_cache && map_busy)
      |=> ##1 s_end_prot;
   endproperty
   a_busy_prot: assert property (p_busy_prot) else $error("busy fault missing");

   property p_invalid_page;
      @(posedge core_clk) disable iff (sys_rst)
      (map_req && map_ack && in_page_cache && !map_busy && !map_entry.valid)
      |=> !attr_req ##1 s_end_page;
   endproperty
   a_invalid_page: assert property (p_invalid_page) else $error("invalid entry fault missing");

   property p_type_page;
      @(posedge core_clk) disable iff (sys_rst)
      s_map_clean ##0 (!map_entry.is_regular && !map_entry.is_thread)
      |=> !attr_req ##1 s_end_page;
   endproperty
   a_type_page: assert property (p_type_page) else $error("page type fault missing");

   property p_thread_prot;
      @(posedge core_clk) disable iff (sys_rst)
      s_map_clean ##0 (map_entry.is_thread && thread_bad)
      |=> !attr_req ##1 s_end_prot;
   endproperty
   a_thread_prot: assert property (p_thread_prot) else $error("thread word fault missing");

   property p_nodebug_nowrite;
      @(posedge core_clk) disable iff (sys_rst)
      (attr_req && attr_ack && !attr_debug)
      |=> !mem_wr ##1 s_end_prot;
   endproperty
   a_nodebug_nowrite: assert property (p_nodebug_nowrite) else $error("non-debug write");

   property p_width;
      @(posedge core_clk) disable iff (sys_rst)
      mem_wr |-> (mem_byte_en == (wide_mode_flag_reg ? dbgw_pkg::BYTES_WIDE : dbgw_pkg::BYTES_NARROW))
                 && (wide_mode_flag_reg || mem_data[63:32] == 32'h0);
   endproperty
   a_width: assert property (p_width) else $error("write width wrong");

endmodule

// >>> hdl/dbgw_pkg.sv
package dbgw_pkg;

   // ----------------------------------------
   // Operation select and widths
   // ----------------------------------------
   localparam logic [31:0] LEAF_DEBUG_WRITE = 32'h0000_0005;
   localparam int          ADDR_W           = 64;
   localparam int          DATA_W           = 64;
   localparam int          PTYPE_W          = 8;
   localparam int          EID_W            = 16;

   // ----------------------------------------
   // Alignment, canonical and page offsets
   // ----------------------------------------
   localparam logic [63:0] ALIGN8_MASK      = 64'h0000_0000_0000_0007;
   localparam logic [63:0] ALIGN4_MASK      = 64'h0000_0000_0000_0003;
   localparam logic [63:0] THREAD_WORD_MASK = 64'h0000_0000_0000_0FF8;
   localparam int          CANON_MSB        = 47;
   localparam logic [7:0]  BYTES_WIDE       = 8'hFF;
   localparam logic [7:0]  BYTES_NARROW     = 8'h0F;

   // ----------------------------------------
   // Page types in the page map entry
   // ----------------------------------------
   localparam logic [7:0] PT_REGULAR = 8'h01;
   localparam logic [7:0] PT_THREAD  = 8'h02;

   // ----------------------------------------
   // Fault kinds and result
   // ----------------------------------------
   typedef enum logic [1:0] {
      DBGW_FLT_NONE = 2'h0,
      DBGW_FLT_PROT = 2'h1,
      DBGW_FLT_PAGE = 2'h2
   } dbgw_fault_e;

   typedef struct packed {
      logic        valid;
      logic        is_regular;
      logic        is_thread;
      logic [15:0] enclave_id;
   } dbgw_map_entry_s;

   typedef struct packed {
      dbgw_fault_e fault;
      logic [63:0] fault_addr;
      logic [15:0] error_code;
   } dbgw_result_s;

   typedef enum logic [4:0] {
      DBGW_IDLE   = 5'b00001,
      DBGW_MAP    = 5'b00010,
      DBGW_ATTR   = 5'b00100,
      DBGW_WRITE  = 5'b01000,
      DBGW_DONE   = 5'b10000
   } dbgw_state_e;

endpackage

// >>> sim/dbgw_page_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Page map, owner attribute and memory responder
// ----------------------------------------
module dbgw_page_model (
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      sys_rst,
   // Answers chosen by the bench
   input  wire logic [1:0]                cfg_delay,
   input  wire logic                      cfg_cache,
   input  wire logic                      cfg_busy,
   input  wire dbgw_pkg::dbgw_map_entry_s cfg_entry,
   input  wire logic                      cfg_debug,
   // Requests
   input  wire logic                      map_req,
   input  wire logic                      attr_req,
   input  wire logic                      mem_wr,
   // Answers
   output logic                           map_ack,
   output logic                           attr_ack,
   output logic                           mem_ack,
   output logic                           in_page_cache,
   output logic                           map_busy,
   output dbgw_pkg::dbgw_map_entry_s      map_entry,
   output logic                           attr_debug,
   // Counts seen
   output int                             map_cnt,
   output int                             wr_cnt
);
   logic [1:0] wait_cnt;

   // Answer lines mean nothing without their ack, so they show the inverse then
   assign in_page_cache = map_ack ? cfg_cache : ~cfg_cache;
   assign map_busy      = map_ack ? cfg_busy : ~cfg_busy;
   assign map_entry     = map_ack ? cfg_entry : ~cfg_entry;
   assign attr_debug    = attr_ack ? cfg_debug : ~cfg_debug;

   // One ack pulse per request, after cfg_delay idle cycles
   always @(posedge core_clk) begin
      map_ack  <= 1'b0;
      attr_ack <= 1'b0;
      mem_ack  <= 1'b0;
      if (sys_rst) begin
         wait_cnt <= 2'h0;
         map_cnt  <= 0;
         wr_cnt   <= 0;
      end else if ((map_req | attr_req | mem_wr) & ~(map_ack | attr_ack | mem_ack)) begin
         wait_cnt <= wait_cnt + 2'h1;
         if (wait_cnt == cfg_delay) begin
            wait_cnt <= 2'h0;
            map_ack  <= map_req;
            attr_ack <= attr_req;
            mem_ack  <= mem_wr;
            map_cnt  <= map_cnt + int'(map_req);
            wr_cnt   <= wr_cnt + int'(mem_wr);
         end
      end
   end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   localparam logic [63:0]    FLAGS_OFF = 64'h0000_0000_0000_0010;
   logic                      core_clk = 1'b0, sys_rst = 1'b1, issue_valid = 1'b0, lm_act = 1'b0, code_long = 1'b0;
   logic                      seg_v = 1'b0, seg_u = 1'b0, cache = 1'b1, busy = 1'b0, dbg = 1'b1;
   logic [1:0]                priv_lvl = 2'h0, dly = 2'h0;
   logic [7:0]                perm = 8'h00, mem_byte_en;
   logic [15:0]               owning_enclave_pointer;
   logic [31:0]               leaf_code = 32'h0000_0000;
   logic [63:0]               ptr = 64'h0, wdata = 64'h0, map_addr, mem_addr, mem_data;
   logic                      issue_ready, done_pulse, map_req, map_ack, in_page_cache, map_busy;
   logic                      attr_req, attr_ack, attr_debug, mem_wr, mem_ack;
   dbgw_pkg::dbgw_map_entry_s ent = '0, map_entry;
   dbgw_pkg::dbgw_result_s    result;
   int                        map_cnt, wr_cnt, mismatches = 0, checks_done = 0;

   dbgw_write_check #(.THREAD_FLAGS_OFFSET(FLAGS_OFF)) i_dbgw_write_check (
      .core_clk, .sys_rst, .issue_valid, .leaf_code, .current_privilege_level(priv_lvl),
      .long_mode_active_bit(lm_act), .code_long_bit(code_long), .target_pointer_register(ptr),
      .write_data_register(wdata), .seg_violation(seg_v), .seg_unusable(seg_u), .issue_ready,
      .done_pulse, .result, .map_req, .map_addr, .map_ack, .in_page_cache, .map_busy, .map_entry,
      .page_permission_bits(perm), .attr_req, .owning_enclave_pointer, .attr_ack, .attr_debug,
      .mem_wr, .mem_addr, .mem_data, .mem_byte_en, .mem_ack);
   dbgw_page_model i_dbgw_page_model (
      .core_clk, .sys_rst, .cfg_delay(dly), .cfg_cache(cache), .cfg_busy(busy), .cfg_entry(ent),
      .cfg_debug(dbg), .map_req, .attr_req, .mem_wr, .map_ack, .attr_ack, .mem_ack, .in_page_cache,
      .map_busy, .map_entry, .attr_debug, .map_cnt, .wr_cnt);

   initial forever #20 core_clk = ~core_clk;

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // A hang costs a mismatch; normal run is well under this
   initial begin
      #(40 * 20000);
      mismatches++;
      print_verdict();
   end

   // Far-side traffic must carry the operation in flight
   always @(posedge core_clk) begin
      if (!sys_rst && map_req) chk("map_addr", ptr, map_addr);
      if (!sys_rst && attr_req) chk("owner id", 64'(ent.enclave_id), 64'(owning_enclave_pointer));
      if (!sys_rst && mem_wr && mem_ack) begin
         chk("write addr", ptr, mem_addr);
         chk("write data", (lm_act & code_long) ? wdata : {32'h0, wdata[31:0]}, mem_data);
         chk("byte enables", (lm_act & code_long) ? 64'hFF : 64'h0F, 64'(mem_byte_en));
      end
   end

   // reference: 0 ok, 1 early fault, 2 page fault, 3 late fault
   function automatic int ref_code();
      logic wide;
      wide = lm_act & code_long;
      if (priv_lvl != 2'h0 || (ptr[2:0] & (wide ? 3'h7 : 3'h3)) != 3'h0) return 1;
      if ((wide && ptr[63:47] != {17{ptr[47]}}) || seg_v || seg_u) return 1;
      if (!cache) return 2;
      if (busy) return 3;
      if (!ent.valid || !(ent.is_regular || ent.is_thread)) return 2;
      if (ent.is_thread && (ptr & 64'hFF8) != (FLAGS_OFF & 64'hFF8)) return 3;
      if (!dbg) return 3;
      return 0;
   endfunction

   task automatic run_op();
      int          code, m0, w0, n, t;
      logic [63:0] pa;
      t  = $urandom % 3;
      pa = {16'h0, 16'($urandom), $urandom} & ~64'hFFF;
      pa |= ($urandom % 3 == 0) ? FLAGS_OFF : 64'($urandom % 512) << 3;
      if ($urandom % 8 == 0) pa |= 64'($urandom % 7 + 1);
      if ($urandom % 8 == 0) pa[62] = 1'b1;
      @(posedge core_clk);
      m0 = map_cnt;
      w0 = wr_cnt;
      issue_valid <= 1'b1;
      leaf_code   <= 32'h0000_0005;
      ptr   <= pa;
      priv_lvl  <= ($urandom % 10 == 0) ? 2'($urandom % 3 + 1) : 2'h0;
      lm_act    <= $urandom % 4 != 0;
      code_long <= $urandom % 4 != 0;
      seg_v <= $urandom % 16 == 0;
      seg_u <= $urandom % 16 == 0;
      cache <= $urandom % 10 != 0;
      busy  <= $urandom % 10 == 0;
      dbg   <= $urandom % 10 != 0;
      dly   <= 2'($urandom);
      perm  <= 8'($urandom);
      wdata <= {$urandom, $urandom};
      ent   <= '{valid: $urandom % 10 != 0, is_regular: t == 1, is_thread: t == 2, enclave_id: 16'($urandom)};
      @(posedge core_clk);
      issue_valid <= 1'b0;
      code = ref_code();
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (done_pulse !== 1'b1 && n < 100);
      chk("done", 1, done_pulse);
      chk("fault kind", (code == 3) ? 1 : code, result.fault);
      chk("error code", 0, result.error_code);
      if (code == 2) chk("fault addr", ptr, result.fault_addr);
      chk("lookups", m0 + int'(code != 1), map_cnt);
      chk("writes", w0 + int'(code == 0), wr_cnt);
      chk("ready after done", 1, issue_ready);
   endtask

   task automatic other_leaf();
      int m0;
      @(posedge core_clk);
      m0 = map_cnt;
      issue_valid <= 1'b1;
      leaf_code   <= 32'h0000_0005 ^ 32'($urandom % 255 + 1);
      repeat (3) @(posedge core_clk);
      issue_valid <= 1'b0;
      #1;
      chk("other leaf ready", 1, issue_ready);
      chk("other leaf lookups", m0, map_cnt);
   endtask

   // Reset in mid-lookup must drop every request and clear the result
   task automatic mid_reset();
      @(posedge core_clk);
      issue_valid <= 1'b1;
      leaf_code   <= 32'h0000_0005;
      ptr         <= 64'h0000_0000_0000_1000;
      priv_lvl    <= 2'h0;
      seg_v       <= 1'b0;
      seg_u       <= 1'b0;
      dly         <= 2'h3;
      @(posedge core_clk);
      issue_valid <= 1'b0;
      @(posedge core_clk);
      sys_rst     <= 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst     <= 1'b0;
      #1;
      chk("reset ready", 1, issue_ready);
      chk("reset requests", 0, {map_req, attr_req, mem_wr, done_pulse});
      chk("reset fault", 0, result.fault);
      chk("reset fault addr", 0, result.fault_addr);
   endtask

   initial begin
      void'($urandom(32'he06c));
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 400; i++) begin
         if (i % 16 == 5) other_leaf();
         if (i % 100 == 50) mid_reset();
         run_op();
      end
      print_verdict();
   end
endmodule
